/* File: fsr_pkg.sv */
// Package with opcode, bit positions and reset values of the flash status readout.
package fsr_pkg;
    localparam logic [7:0] FSR_OPC_STATUS    = 8'hd7;   // Read-status opcode.
    localparam logic [3:0] FSR_DENSITY_CODE  = 4'h5;    // Density code; value is arbitrary.
    localparam int         FSR_RDY_BIT       = 7;       // Ready/busy position in both bytes.
    localparam int         FSR_CMP_BIT       = 6;       // Compare result position, byte one.
    localparam int         FSR_DEN_LSB       = 2;       // Density field low bit, byte one.
    localparam int         FSR_PROT_BIT      = 1;       // Protection position, byte one.
    localparam int         FSR_PSIZE_BIT     = 0;       // Page size position, byte one.
    localparam int         FSR_FAIL_BIT      = 5;       // Erase/program failure, byte two.
    localparam int         FSR_LOCK_BIT      = 3;       // Lockdown allowed, byte two.
    localparam int         FSR_BUF2_BIT      = 2;       // Buffer two suspend, byte two.
    localparam int         FSR_BUF1_BIT      = 1;       // Buffer one suspend, byte two.
    localparam int         FSR_PAUSE_BIT     = 0;       // Erase suspend, byte two.
    localparam logic [2:0] FSR_BIT_CNT_RST   = 3'h0;    // Bit counter value after reset.
    localparam logic       FSR_CMP_RST       = 1'b0;    // Compare flag after reset.
    localparam logic       FSR_FAIL_RST      = 1'b0;    // Failure flag after reset.
    // Phases of one select frame.
    typedef enum logic [1:0] {FSR_IDLE, FSR_OPCODE, FSR_STREAM, FSR_IGNORE} fsr_phase_t;
endpackage : fsr_pkg

/* File: fsr_status_if.sv */
// Interface carrying the two status bytes from the status keeper to the shifter.
`timescale 1ns/1ns
interface fsr_status_if;
    logic [7:0] first_byte;   // Status byte one.
    logic [7:0] second_byte;  // Status byte two.
    modport src (output first_byte, output second_byte);
    modport dst (input  first_byte, input  second_byte);
endinterface : fsr_status_if

/* File: fsr_status_bytes.sv */
// Status keeper: sticky compare and failure flags and assembly of both status bytes.
`timescale 1ns/1ns
module fsr_status_bytes
    import fsr_pkg::*;
(
    // Clock and reset.
    input  wire logic core_clk_i,
    input  wire logic rstn_i,
    // Internal engine reports.
    input  wire logic busy_i,
    input  wire logic cmp_done_i,
    input  wire logic cmp_mismatch_i,
    input  wire logic ep_done_i,
    input  wire logic ep_aborted_i,
    input  wire logic ep_fail_i,
    input  wire logic protect_en_i,
    input  wire logic page_256_i,
    input  wire logic lockdown_allowed_flag_i,
    input  wire logic buf2_suspend_flag_i,
    input  wire logic buf1_suspend_flag_i,
    input  wire logic erase_paused_flag_i,
    // Assembled bytes.
    fsr_status_if.src st
);
    logic cmp_q;   // Last compare result.
    logic fail_q;  // Last erase/program failure.

    // Compare result only moves when a compare finishes; failure only on a finished, non-aborted operation.
    always_ff @(posedge core_clk_i) begin
        if (!rstn_i) begin
            cmp_q <= FSR_CMP_RST;
            fail_q <= FSR_FAIL_RST;
        end else begin
            if (cmp_done_i) begin
                cmp_q <= cmp_mismatch_i;
            end
            if (ep_done_i && !ep_aborted_i) begin
                fail_q <= ep_fail_i;
            end
        end
    end

    // Byte one: ready, compare, density, protection, page size.
    always_comb begin
        st.first_byte                                 = '0;
        st.first_byte[FSR_RDY_BIT]                    = !busy_i;
        st.first_byte[FSR_CMP_BIT]                    = cmp_q;
        st.first_byte[FSR_DEN_LSB+3:FSR_DEN_LSB]      = FSR_DENSITY_CODE;
        st.first_byte[FSR_PROT_BIT]                   = protect_en_i;
        st.first_byte[FSR_PSIZE_BIT]                  = page_256_i;
    end

    // Byte two: reserved bits stay zero from the default.
    always_comb begin
        st.second_byte                 = '0;
        st.second_byte[FSR_RDY_BIT]    = !busy_i;
        st.second_byte[FSR_FAIL_BIT]   = fail_q;
        st.second_byte[FSR_LOCK_BIT]   = lockdown_allowed_flag_i;
        st.second_byte[FSR_BUF2_BIT]   = buf2_suspend_flag_i;
        st.second_byte[FSR_BUF1_BIT]   = buf1_suspend_flag_i;
        st.second_byte[FSR_PAUSE_BIT]  = erase_paused_flag_i;
    end

    // An aborted operation must leave the failure flag as it was.
    a_abort_keeps_fail: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
        (ep_done_i && ep_aborted_i) |=> fail_q == $past(fail_q))
        else $error("Failure flag changed on aborted operation.");
    // Compare flag moves only after a compare completes.
    a_cmp_only_done: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
        (cmp_q != $past(cmp_q)) |-> $past(cmp_done_i))
        else $error("Compare flag changed without a compare completing.");
endmodule : fsr_status_bytes

/* File: fsr_top.sv */
// Serial status-read front end: samples select and clock, decodes the opcode, streams status bytes.
//
// Behaviour
// - Status read answered anytime, even while busy.
// - After opcode, one status bit per clock.
// - After byte two, repeat from byte one.
// - Bit seven of both bytes is ready flag.
// - Deselect ends read anytime; output floats.
// - Byte one bit six shows compare mismatch.
// - Compare bit changes only on compare completion.
// - Byte one bits five to two: density code.
// - Byte one bit one: protection enabled.
// - Byte one bit zero: 256-byte page size.
// - Byte two bits six, four read zero.
// - Byte two bit five: erase/program failed.
// - Aborted operations never set failure bit.
// - Failure bit re-evaluated after each operation; aborted ones leave it as it was.
// - Byte two bit three: lockdown still allowed.
// - Byte two bit two: buffer two suspended.
// - Byte two bit one: buffer one suspended.
// - Byte two bit zero: erase suspended.
`timescale 1ns/1ns
module fsr_top
    import fsr_pkg::*;
(
    // Clock and reset.
    input  wire logic core_clk_i,
    input  wire logic rstn_i,
    // Serial pins, asynchronous to the core clock.
    input  wire logic spi_csn_i,
    input  wire logic spi_sck_i,
    input  wire logic spi_si_i,
    output logic      spi_so_o,
    output logic      spi_so_oe_o,
    // Internal engine reports.
    input  wire logic busy_i,
    input  wire logic cmp_done_i,
    input  wire logic cmp_mismatch_i,
    input  wire logic ep_done_i,
    input  wire logic ep_aborted_i,
    input  wire logic ep_fail_i,
    input  wire logic protect_en_i,
    input  wire logic page_256_i,
    input  wire logic lockdown_allowed_flag_i,
    input  wire logic buf2_suspend_flag_i,
    input  wire logic buf1_suspend_flag_i,
    input  wire logic erase_paused_flag_i,
    // Buffer write guards for the command decoder.
    output logic      buf1_write_block_o,
    output logic      buf2_write_block_o
);
    // Two-stage synchronisers for the three pin inputs.
    logic [2:0] sync1_q;     // First stage, read only by the second.
    logic [2:0] sync2_q;     // Second stage.
    logic       sck_prev_q;  // Previous synchronised clock for edge finding.

    always_ff @(posedge core_clk_i) begin
        if (!rstn_i) begin
            // Both stages start at the idle pin levels, so reset shows no false select.
            sync1_q    <= 3'h1;
            sync2_q    <= 3'h1;
            sck_prev_q <= 1'b0;
        end else begin
            sync1_q    <= {spi_si_i, spi_sck_i, spi_csn_i};
            sync2_q    <= sync1_q;
            sck_prev_q <= sync2_q[1];
        end
    end

    // Decoded pin views; edges are detected on synchronised values only.
    wire cs_act   = !sync2_q[0];
    wire si_s     = sync2_q[2];
    wire sck_rise = sync2_q[1] && !sck_prev_q;
    wire sck_fall = !sync2_q[1] && sck_prev_q;

    // Status bytes come from the keeper over the interface.
    fsr_status_if st_if ();
    fsr_status_bytes u_bytes (
        .core_clk_i              (core_clk_i),
        .rstn_i                  (rstn_i),
        .busy_i                  (busy_i),
        .cmp_done_i              (cmp_done_i),
        .cmp_mismatch_i          (cmp_mismatch_i),
        .ep_done_i               (ep_done_i),
        .ep_aborted_i            (ep_aborted_i),
        .ep_fail_i               (ep_fail_i),
        .protect_en_i            (protect_en_i),
        .page_256_i              (page_256_i),
        .lockdown_allowed_flag_i (lockdown_allowed_flag_i),
        .buf2_suspend_flag_i     (buf2_suspend_flag_i),
        .buf1_suspend_flag_i     (buf1_suspend_flag_i),
        .erase_paused_flag_i     (erase_paused_flag_i),
        .st                      (st_if.src)
    );

    // Frame state.
    fsr_phase_t phase_q;     // Current phase of the frame.
    logic [2:0] bit_cnt_q;   // Bit position within the current byte.
    logic [6:0] opc_q;       // Opcode bits received so far.
    logic       byte_sel_q;  // Zero for status byte one, one for byte two.
    logic [7:0] shift_q;     // Byte being shifted out, latched at byte start.
    logic       so_q;        // Serial output bit.
    logic       oe_q;        // Serial output enable.

    // Opcode is complete on the eighth rising edge.
    wire [7:0] opc_full  = {opc_q, si_s};
    wire       opc_last  = (bit_cnt_q == 3'h7);
    wire       opc_match = (opc_full == FSR_OPC_STATUS);
    // Next byte is chosen from the alternation; busy is sampled fresh for each byte.
    wire [7:0] next_byte = byte_sel_q ? st_if.second_byte : st_if.first_byte;
    wire       byte_end  = (bit_cnt_q == 3'h7);

    // Frame sequencer: opcode collection, then endless alternation of bytes.
    // Output changes on the falling edge so the host samples a stable bit on the rising one.
    always_ff @(posedge core_clk_i) begin
        if (!rstn_i) begin
            phase_q    <= FSR_IDLE;
            bit_cnt_q  <= FSR_BIT_CNT_RST;
            opc_q      <= '0;
            byte_sel_q <= 1'b0;
            shift_q    <= '0;
            so_q       <= 1'b0;
            oe_q       <= 1'b0;
        end else if (!cs_act) begin
            // Deselect aborts at any bit and releases the output.
            phase_q   <= FSR_IDLE;
            bit_cnt_q <= FSR_BIT_CNT_RST;
            oe_q      <= 1'b0;
        end else begin
            unique case (phase_q)
                FSR_IDLE: begin
                    // Select seen: start collecting opcode; busy does not matter.
                    phase_q    <= FSR_OPCODE;
                    bit_cnt_q  <= FSR_BIT_CNT_RST;
                    byte_sel_q <= 1'b0;
                    if (sck_rise) begin
                        opc_q     <= {opc_q[5:0], si_s};
                        bit_cnt_q <= 3'h1;
                    end
                end
                FSR_OPCODE: begin
                    if (sck_rise) begin
                        opc_q     <= opc_full[6:0];
                        bit_cnt_q <= bit_cnt_q + 3'h1;
                        if (opc_last) begin
                            // Status read taken; anything else is left to other decoders.
                            phase_q <= opc_match ? FSR_STREAM : FSR_IGNORE;
                            shift_q <= st_if.first_byte;
                        end
                    end
                end
                FSR_STREAM: begin
                    if (sck_fall) begin
                        // Most significant bit first, one bit per clock.
                        so_q    <= shift_q[7 - bit_cnt_q];
                        oe_q    <= 1'b1;
                    end
                    if (sck_rise) begin
                        bit_cnt_q <= bit_cnt_q + 3'h1;
                        if (byte_end) begin
                            // Wrap to the other byte with freshly sampled contents.
                            byte_sel_q <= !byte_sel_q;
                            shift_q    <= byte_sel_q ? st_if.first_byte : st_if.second_byte;
                        end
                    end
                end
                FSR_IGNORE: begin
                    oe_q <= 1'b0;
                end
            endcase
        end
    end

    // Output pins.
    assign spi_so_o    = so_q;
    assign spi_so_oe_o = oe_q;

    // Suspended buffers may not be modified by any command.
    assign buf1_write_block_o = buf1_suspend_flag_i;
    assign buf2_write_block_o = buf2_suspend_flag_i;

    // Deselect must release the output within one cycle.
    a_desel_floats: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
        !cs_act |=> !spi_so_oe_o)
        else $error("Output still driven after deselect.");
    // The output is never driven outside the streaming phase.
    a_oe_only_stream: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
        spi_so_oe_o |-> $past(phase_q) == FSR_STREAM)
        else $error("Output driven outside status stream.");
    // The byte selection alternates at the end of every byte.
    a_byte_wrap: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
        (phase_q == FSR_STREAM && cs_act && sck_rise && byte_end) |=> byte_sel_q != $past(byte_sel_q))
        else $error("Status byte did not alternate.");
    // First bit of byte one is the inverse of busy when latched after the opcode.
    a_msb_ready: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
        (phase_q == FSR_OPCODE && cs_act && sck_rise && opc_last) |=> shift_q[7] == !$past(busy_i))
        else $error("Ready bit not at the head of the byte.");
    // A matching opcode starts the stream even while busy.
    a_busy_accept: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
        (phase_q == FSR_OPCODE && cs_act && sck_rise && opc_last && opc_match) |=> phase_q == FSR_STREAM)
        else $error("Status opcode not accepted.");
    // Reserved bits of byte two always zero.
    a_reserved_zero: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
        st_if.second_byte[6] == 1'b0 && st_if.second_byte[4] == 1'b0)
        else $error("Reserved status bit set.");

    // The serial output only moves on a falling clock edge of the stream.
    a_so_holds: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
        !(phase_q == FSR_STREAM && cs_act && sck_fall) |=> $stable(spi_so_o))
        else $error("Serial output moved off a falling edge.");

    // The output is switched on by a falling edge, never by a rising one.
    a_oe_after_fall: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
        $rose(spi_so_oe_o) |-> $past(sck_fall))
        else $error("Output enabled without a falling edge.");

    // Opcode bits are counted only on rising clock edges.
    a_opc_cnt_hold: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
        (phase_q == FSR_OPCODE && cs_act && !sck_rise) |=> bit_cnt_q == $past(bit_cnt_q))
        else $error("Opcode counter moved without a clock.");

    // Each rising edge of the stream consumes exactly one bit.
    a_stream_cnt_step: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
        (phase_q == FSR_STREAM && cs_act && sck_rise) |=> bit_cnt_q == $past(bit_cnt_q) + 3'h1)
        else $error("Stream bit counter did not advance by one.");

    // A foreign command never drives the output.
    a_ignore_silent: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
        phase_q == FSR_IGNORE |=> !spi_so_oe_o)
        else $error("Output driven for a foreign opcode.");

    // Any other opcode is left alone for the rest of the frame.
    a_other_opc_ignored: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
        (phase_q == FSR_OPCODE && cs_act && sck_rise && opc_last && !opc_match) |=> phase_q == FSR_IGNORE)
        else $error("Foreign opcode not ignored.");

    // Deselect returns the frame to idle at any bit.
    a_desel_idle: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
        !cs_act |=> phase_q == FSR_IDLE)
        else $error("Frame not ended by deselect.");

    // Away from a byte end the byte selection stays put.
    a_byte_sel_hold: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
        (phase_q == FSR_STREAM && !(cs_act && sck_rise && byte_end)) |=> byte_sel_q == $past(byte_sel_q))
        else $error("Byte selection moved inside a byte.");

    // A byte being shifted is never reloaded halfway through.
    a_shift_hold: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
        (phase_q == FSR_STREAM && !(cs_act && sck_rise && byte_end)) |=> $stable(shift_q))
        else $error("Shift byte reloaded inside a byte.");

    // After byte one comes a fresh copy of byte two.
    a_fresh_second: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
        (phase_q == FSR_STREAM && cs_act && sck_rise && byte_end && !byte_sel_q)
        |=> shift_q == $past(st_if.second_byte))
        else $error("Byte two not loaded after byte one.");

    // After byte two comes a fresh copy of byte one.
    a_fresh_first: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
        (phase_q == FSR_STREAM && cs_act && sck_rise && byte_end && byte_sel_q)
        |=> shift_q == $past(st_if.first_byte))
        else $error("Byte one not loaded after byte two.");

    // Write guards follow the suspend flags at all times.
    a_block_guard: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
        buf1_write_block_o == buf1_suspend_flag_i && buf2_write_block_o == buf2_suspend_flag_i)
        else $error("Buffer write guard differs from suspend flag.");

    // Select is seen exactly two core edges after the pin.
    a_sync_latency: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
        cs_act == !$past(spi_csn_i, 2))
        else $error("Select synchroniser latency wrong.");

    // Selection always starts opcode collection, busy or not.
    a_select_starts: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
        (phase_q == FSR_IDLE && cs_act) |=> phase_q == FSR_OPCODE)
        else $error("Selection did not start a command.");

    // The density field is the fixed code.
    a_density_fixed: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
        st_if.first_byte[FSR_DEN_LSB+3:FSR_DEN_LSB] == FSR_DENSITY_CODE)
        else $error("Density code not fixed.");

    // Both bytes carry the current ready state.
    a_ready_both: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
        st_if.first_byte[FSR_RDY_BIT] == !busy_i && st_if.second_byte[FSR_RDY_BIT] == !busy_i)
        else $error("Ready bit does not follow busy.");

    // The stream runs for as long as select stays active.
    a_stream_stays: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
        (phase_q == FSR_STREAM && cs_act) |=> phase_q == FSR_STREAM)
        else $error("Stream stopped while selected.");

    // The first bit of a byte is its most significant one.
    a_first_bit_head: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
        (phase_q == FSR_STREAM && cs_act && sck_fall && bit_cnt_q == 3'h0) |=> spi_so_o == $past(shift_q[7]))
        else $error("Byte does not start with its top bit.");

    // Once driving, the output stays enabled while selected.
    a_oe_stays: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
        (spi_so_oe_o && cs_act) |=> spi_so_oe_o)
        else $error("Output released while still selected.");
endmodule : fsr_top

/* File: fsr_host_model.sv */
// Behavioural host controller that frames status reads on the serial pins.
`timescale 1ns/1ns
module fsr_host_model (
    // Core clock used to pace the serial pins.
    input  wire logic       clk_i,
    // Serial pins towards the device.
    output logic            csn_o,
    output logic            sck_o,
    output logic            si_o,
    input  wire logic       so_i,
    // Each whole byte received is shown here for one half period.
    output logic            rx_valid_o,
    output logic [7:0]      rx_byte_o
);
    // The serial clock stands low and select stands high between frames.
    initial begin
        csn_o      = 1'b1;
        sck_o      = 1'b0;
        si_o       = 1'b0;
        rx_valid_o = 1'b0;
        rx_byte_o  = 8'h00;
    end

    // Waits a number of core cycles, then moves off the edge.
    task automatic half(input int n);
        repeat (n) @(posedge clk_i);
        #2;
    endtask : half

    // One frame: select, opcode MSB first, then nbits sampled on rising clock edges.
    task automatic frame(input logic [7:0] opc, input int nbits, input int hc);
        logic [7:0] sh;
        sh    = 8'h00;
        csn_o = 1'b0;
        half(hc);
        for (int i = 7; i >= 0; i--) begin
            si_o = opc[i];
            half(hc);
            sck_o = 1'b1;
            half(hc);
            sck_o = 1'b0;
        end
        for (int i = 0; i < nbits; i++) begin
            // The input line toggles so a stale value is never mistaken for data.
            si_o = ~si_o;
            half(hc);
            sck_o = 1'b1;
            sh    = {sh[6:0], so_i};
            if (i % 8 == 7) begin
                rx_byte_o  = sh;
                rx_valid_o = 1'b1;
            end
            half(hc);
            sck_o      = 1'b0;
            rx_valid_o = 1'b0;
        end
        half(hc);
        csn_o = 1'b1;
        half(hc);
    endtask : frame
endmodule : fsr_host_model

/* File: test_flash_status_readout.sv */
// Self-checking testbench of the serial status readout.
`timescale 1ns/1ns
module test_flash_status_readout;
    import fsr_pkg::*;
    logic       core_clk_i, rstn_i, busy_i, cmp_done_i, cmp_mismatch_i, ep_done_i, ep_aborted_i, ep_fail_i;
    logic       protect_en_i, page_256_i, lockdown_allowed_flag_i, buf2_suspend_flag_i;
    logic       buf1_suspend_flag_i, erase_paused_flag_i;
    wire        csn, sck, si, rx_valid;
    wire  [7:0] rx_byte;
    logic       so, oe, b1_blk, b2_blk, oe_hit, cmp_m, fail_m, refused;
    // A released line has no pull, so the host sees the inverse of the last bit.
    wire        so_line = oe ? so : ~so;
    logic [7:0] exp_q[$];   // Expected bytes in the order the host receives them.
    int         bad_count, comparisons, cycles;
    int         seed = 32'h47d0175e;

    fsr_top uut (.core_clk_i(core_clk_i), .rstn_i(rstn_i), .spi_csn_i(csn), .spi_sck_i(sck), .spi_si_i(si),
        .spi_so_o(so), .spi_so_oe_o(oe), .busy_i(busy_i), .cmp_done_i(cmp_done_i),
        .cmp_mismatch_i(cmp_mismatch_i), .ep_done_i(ep_done_i), .ep_aborted_i(ep_aborted_i),
        .ep_fail_i(ep_fail_i), .protect_en_i(protect_en_i), .page_256_i(page_256_i),
        .lockdown_allowed_flag_i(lockdown_allowed_flag_i), .buf2_suspend_flag_i(buf2_suspend_flag_i),
        .buf1_suspend_flag_i(buf1_suspend_flag_i), .erase_paused_flag_i(erase_paused_flag_i),
        .buf1_write_block_o(b1_blk), .buf2_write_block_o(b2_blk));
    fsr_host_model host (.clk_i(core_clk_i), .csn_o(csn), .sck_o(sck), .si_o(si), .so_i(so_line),
        .rx_valid_o(rx_valid), .rx_byte_o(rx_byte));

    // Clock of 50 ns period.
    initial begin
        core_clk_i = 1'b0;
        forever #25 core_clk_i = ~core_clk_i;
    end

    // Compares one byte and counts it.
    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value at %0t: byte %h expected %h", $time, got, exp);
        end
    endtask : chk_byte

    // Compares one flag and counts it.
    task automatic chk_bit(input logic got, input logic exp);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value at %0t: flag %b expected %b", $time, got, exp);
        end
    endtask : chk_bit

    // Prints the counts and the verdict, then stops.
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : conclude

    // Queues the bytes of one frame from the present inputs and the modelled sticky flags.
    task automatic expect_bytes(input int n);
        for (int i = 0; i < n; i++) begin
            if (i % 2 == 0) exp_q.push_back({~busy_i, cmp_m, FSR_DENSITY_CODE, protect_en_i, page_256_i});
            else exp_q.push_back({~busy_i, 1'b0, fail_m, 1'b0, lockdown_allowed_flag_i, buf2_suspend_flag_i,
                                  buf1_suspend_flag_i, erase_paused_flag_i});
        end
    endtask : expect_bytes

    // Moves inputs a fixed delay after the rising edge.
    task automatic step();
        @(posedge core_clk_i);
        #2;
    endtask : step

    // Notes whether the output was ever enabled; a hang ends the run as a mismatch.
    always @(posedge core_clk_i) begin
        if (oe === 1'b1) oe_hit = 1'b1;
        cycles++;
        if (cycles == 20000) begin
            bad_count++;
            conclude();
        end
    end

    // Takes the oldest note off the queue whenever the host completes a byte of a frame that is not refused.
    initial forever begin
        @(posedge rx_valid);
        if (refused) chk_bit(oe, 1'b0);
        else begin
            chk_bit(oe, 1'b1);
            if (exp_q.size() == 0) chk_bit(1'b1, 1'b0);
            else chk_byte(rx_byte, exp_q.pop_front());
        end
    end

    initial begin
        {rstn_i, busy_i, cmp_done_i, cmp_mismatch_i, ep_done_i, ep_aborted_i, ep_fail_i} = 7'h00;
        {protect_en_i, page_256_i, lockdown_allowed_flag_i, buf2_suspend_flag_i} = 4'h0;
        {buf1_suspend_flag_i, erase_paused_flag_i, cmp_m, fail_m, oe_hit, refused} = 6'h00;
        repeat (10) step();
        rstn_i = 1'b1;
        chk_bit(oe, 1'b0);
        repeat (3) step();
        // Right after reset, read part of a frame while busy; the sticky flags read clear.
        busy_i = 1'b1;
        expect_bytes(2);
        host.frame(FSR_OPC_STATUS, 20, 4);
        chk_bit(oe, 1'b0);
        for (int r = 0; r < 8; r++) begin
            {protect_en_i, page_256_i, lockdown_allowed_flag_i, buf2_suspend_flag_i, buf1_suspend_flag_i,
             erase_paused_flag_i, busy_i} = 7'($random(seed));
            {cmp_mismatch_i, ep_fail_i} = 2'($random(seed));
            ep_aborted_i = r[0];
            cmp_done_i   = (r % 3 == 0);
            ep_done_i    = 1'b1;
            if (cmp_done_i) cmp_m = cmp_mismatch_i;
            if (!ep_aborted_i) fail_m = ep_fail_i;
            step();
            {cmp_done_i, ep_done_i} = 2'b00;
            cmp_mismatch_i = ~cmp_mismatch_i;
            step();
            chk_bit(b1_blk, buf1_suspend_flag_i);
            chk_bit(b2_blk, buf2_suspend_flag_i);
            expect_bytes(5);
            host.frame(FSR_OPC_STATUS, 40, (r == 5) ? 6 : 4);
            chk_bit(oe, 1'b0);
        end
        // A reset in mid-run must clear both sticky flags that were just set.
        {cmp_done_i, cmp_mismatch_i, ep_done_i, ep_aborted_i, ep_fail_i} = 5'h1d;
        step();
        {cmp_done_i, ep_done_i, rstn_i} = 3'h0;
        repeat (2) step();
        {rstn_i, cmp_m, fail_m} = 3'h4;
        repeat (3) step();
        expect_bytes(2);
        host.frame(FSR_OPC_STATUS, 16, 4);
        // Another opcode must leave the output disabled for the whole frame.
        {oe_hit, refused} = 2'b01;
        host.frame(8'h9f, 24, 4);
        chk_bit(oe_hit, 1'b0);
        chk_bit(exp_q.size() == 0, 1'b1);
        conclude();
    end
endmodule : test_flash_status_readout
